// [rtl/tcb_bank.sv]
// scan timer/counter bank: 64 shared channels evaluated one request at a time
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - 64 channels, references 600-677, each done
// - presets are four bcd digits 0001-9999
// - enabled timer counts ticks from zero
// - ref 770 selects 0.01 s ticks
// - timer done at preset, stops at 9999
// - timer clears on disable or stop
// - tick derives from the crystal clock
// - counter counts only rising count edges
// - reset true holds counter at zero
// - count with reset records nothing
// - counter done at preset, keeps counting
// - counter values survive power loss
// - 674-677 use external presets, default 9999
// - setpoint unit writes both bytes together
// - preset register pairs 564/565 through 572/573
// - dead region: timers clear, counters freeze
module tcb_bank #(
	parameter int NCHAN = tcb_pkg::NUM_CHAN,
	parameter int FINE_TICK_CYC = tcb_pkg::FINE_TICK_CYC
) (
	input wire logic ref_clk,
	input wire logic resetn,
	input wire logic ce,
	// register port
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	// scan engine
	input wire logic scan_start,
	input wire logic ev_req,
	output logic ev_ready,
	input wire logic [tcb_pkg::CHAN_W-1:0] ev_chan,
	input wire logic ev_is_timer,
	input wire logic ev_enable,
	input wire logic ev_reset,
	input wire logic ev_region_on,
	input wire logic [15:0] ev_preset,
	output logic ev_ack,
	output logic ev_done,
	output logic [15:0] ev_acc,
	// external setpoint unit
	input wire logic ext_set,
	input wire logic [1:0] ext_sel,
	input wire logic [15:0] ext_bcd
);
	localparam int TW = $clog2(FINE_TICK_CYC + 1);

	if (NCHAN < 1 || NCHAN > tcb_pkg::NUM_CHAN || FINE_TICK_CYC < 1) begin : g_chk
		$error("tcb_bank: unsupported channel count or tick length");
	end

	tcb_pkg::tcb_state_e state_q;
	logic [7:0] ctrl_q;
	logic run_q;
	logic [TW-1:0] tick_div_q;
	logic [3:0] coarse_q;
	logic [3:0] tick_acc_q;
	logic [3:0] scan_ticks_q;
	logic [15:0] ext_q [tcb_pkg::NUM_EXT];
	logic [tcb_pkg::CHAN_W-1:0] chan_q;
	logic tmr_q, en_q, rst_q, reg_on_q;
	logic [15:0] preset_q;
	logic [tcb_pkg::CHAN_W-1:0] sweep_q;
	logic [tcb_pkg::WORD_W-1:0] rd_word;
	logic [tcb_pkg::WORD_W-1:0] calc_word;
	logic [tcb_pkg::WORD_W-1:0] wr_word;
	logic mem_rd, mem_wr;
	logic [tcb_pkg::CHAN_W-1:0] mem_rd_addr, mem_wr_addr;
	logic fine_tick, base_tick;
	logic [15:0] eff_preset;

	// add a small digit to a four-digit bcd value, saturating at 9999
	function automatic logic [15:0] bcd_add(input logic [15:0] v, input logic [3:0] d);
		logic [15:0] r;
		logic [4:0] s;
		logic [3:0] c;
		r = v;
		c = d;
		for (int i = 0; i < 4; i++) begin
			s = {1'b0, r[i*4 +: 4]} + {1'b0, c};
			if (s > 5'd9) begin
				r[i*4 +: 4] = 4'((s - 5'd10));
				c = 4'h1;
			end else begin
				r[i*4 +: 4] = s[3:0];
				c = 4'h0;
			end
		end
		if (c != 4'h0) begin
			r = tcb_pkg::BCD_MAX; // stop at the top value
		end
		return r;
	endfunction : bcd_add

	// valid preset: every digit 0-9 and at least 0001, else clamp
	function automatic logic [15:0] fix_preset(input logic [15:0] p);
		logic ok;
		ok = 1'b1;
		for (int i = 0; i < 4; i++) begin
			if (p[i*4 +: 4] > 4'h9) begin
				ok = 1'b0;
			end
		end
		if (!ok) begin
			return tcb_pkg::BCD_MAX;
		end
		if (p < tcb_pkg::BCD_MIN) begin
			return tcb_pkg::BCD_MIN;
		end
		return p;
	endfunction : fix_preset

	// control register: fine tick select, run, external unit present
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			ctrl_q <= tcb_pkg::CTRL_RESET;
		end else if (ce && reg_wr && reg_addr == tcb_pkg::ADDR_CTRL) begin
			ctrl_q <= reg_wdata;
		end
	end

	// external preset bytes; the setpoint unit loads a whole value at once
	for (genvar g = 0; g < tcb_pkg::NUM_EXT; g++) begin : g_ext
		always_ff @(posedge ref_clk or negedge resetn) begin
			if (!resetn) begin
				ext_q[g] <= tcb_pkg::EXT_PRESET_RESET;
			end else if (ce && ext_set && ext_sel == 2'(g)) begin
				ext_q[g] <= ext_bcd;
			end else if (ce && reg_wr && reg_addr == tcb_pkg::ADDR_EXT_BASE + 8'(2 * g)) begin
				ext_q[g][7:0] <= reg_wdata;
			end else if (ce && reg_wr && reg_addr == tcb_pkg::ADDR_EXT_BASE + 8'(2 * g + 1)) begin
				ext_q[g][15:8] <= reg_wdata;
			end
		end
	end

	// register read data, valid in the cycle after the read strobe
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			reg_rdata <= 8'h00;
		end else if (ce) begin
			reg_rdata <= 8'h00;
			if (reg_rd) begin
				if (reg_addr == tcb_pkg::ADDR_CTRL) begin
					reg_rdata <= ctrl_q;
				end else if (reg_addr == tcb_pkg::ADDR_STATUS) begin
					reg_rdata <= {5'h00, state_q == tcb_pkg::ST_IDLE, run_q, ctrl_q[tcb_pkg::CTRL_FINE_BIT]};
				end else if (reg_addr == tcb_pkg::ADDR_TICKS) begin
					reg_rdata <= {4'h0, scan_ticks_q};
				end else if (reg_addr[7:3] == tcb_pkg::ADDR_EXT_BASE[7:3]) begin
					reg_rdata <= reg_addr[0] ? ext_q[reg_addr[2:1]][15:8] : ext_q[reg_addr[2:1]][7:0];
				end
			end
		end
	end

	// fine tick from a divider of the crystal clock, never the mains
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			tick_div_q <= '0;
		end else if (ce) begin
			if (!run_q || fine_tick) begin
				tick_div_q <= '0;
			end else begin
				tick_div_q <= tick_div_q + TW'(1);
			end
		end
	end
	assign fine_tick = run_q && (tick_div_q == TW'(FINE_TICK_CYC - 1));

	// coarse prescale: one 0.1 s tick per ten fine ticks unless 770 is set
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			coarse_q <= 4'h0;
		end else if (ce && fine_tick) begin
			coarse_q <= (coarse_q == tcb_pkg::COARSE_DIV) ? 4'h0 : coarse_q + 4'h1;
		end
	end
	assign base_tick = fine_tick && (ctrl_q[tcb_pkg::CTRL_FINE_BIT] || coarse_q == tcb_pkg::COARSE_DIV);

	// ticks gathered over a scan; latched at scan start for every timer of that scan
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			tick_acc_q <= 4'h0;
			scan_ticks_q <= 4'h0;
		end else if (ce) begin
			if (scan_start) begin
				scan_ticks_q <= tick_acc_q;
				tick_acc_q <= base_tick ? 4'h1 : 4'h0;
			end else if (base_tick && tick_acc_q != tcb_pkg::MAX_SCAN_TICKS) begin
				tick_acc_q <= tick_acc_q + 4'h1;
			end
		end
	end

	// run level, delayed once so a stop is seen as an edge
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			run_q <= 1'b0;
		end else if (ce) begin
			run_q <= ctrl_q[tcb_pkg::CTRL_RUN_BIT];
		end
	end

	// request capture
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			chan_q <= '0;
			tmr_q <= 1'b0;
			en_q <= 1'b0;
			rst_q <= 1'b0;
			reg_on_q <= 1'b0;
			preset_q <= tcb_pkg::BCD_MAX;
		end else if (ce && ev_req && ev_ready) begin
			chan_q <= ev_chan;
			tmr_q <= ev_is_timer;
			en_q <= ev_enable;
			rst_q <= ev_reset;
			reg_on_q <= ev_region_on;
			preset_q <= ev_preset;
		end
	end

	// special channels never use the internal preset
	always_comb begin
		eff_preset = fix_preset(preset_q);
		if (chan_q >= tcb_pkg::EXT_CHAN_BASE) begin
			eff_preset = ctrl_q[tcb_pkg::CTRL_EXTP_BIT] ? fix_preset(ext_q[chan_q[1:0]])
				: tcb_pkg::BCD_MAX;
		end
	end

	// per-channel update from the stored word
	always_comb begin
		logic [15:0] acc;
		logic prev;
		acc = rd_word[15:0];
		prev = rd_word[tcb_pkg::F_PREV];
		if (tmr_q) begin
			if (!en_q || !reg_on_q) begin
				acc = 16'h0000;
			end else if (prev && rd_word[tcb_pkg::F_TIMER]) begin
				acc = bcd_add(acc, scan_ticks_q);
			end else begin
				acc = 16'h0000;
			end
			calc_word = {en_q && reg_on_q, 1'b1, (en_q && reg_on_q && acc >= eff_preset), acc};
		end else begin
			if (!rd_word[tcb_pkg::F_TIMER] && !reg_on_q) begin
				calc_word = rd_word;
			end else begin
				if (rst_q) begin
					acc = 16'h0000;
				end else if (rd_word[tcb_pkg::F_TIMER]) begin
					acc = 16'h0000;
				end else if (en_q && !prev) begin
					acc = bcd_add(acc, 4'h1);
				end
				calc_word = {en_q, 1'b0, acc >= eff_preset, acc};
			end
		end
	end

	// sequencer: idle, one compute cycle per request, sweep after a stop
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			state_q <= tcb_pkg::ST_IDLE;
			sweep_q <= '0;
		end else if (ce) begin
			case (state_q)
				tcb_pkg::ST_IDLE: begin
					if (run_q && !ctrl_q[tcb_pkg::CTRL_RUN_BIT]) begin
						state_q <= tcb_pkg::ST_SWEEP_RD;
						sweep_q <= '0;
					end else if (ev_req && ev_ready) begin
						state_q <= tcb_pkg::ST_CALC;
					end
				end
				tcb_pkg::ST_CALC: begin
					state_q <= tcb_pkg::ST_IDLE;
				end
				tcb_pkg::ST_SWEEP_RD: begin
					state_q <= tcb_pkg::ST_SWEEP_WR;
				end
				tcb_pkg::ST_SWEEP_WR: begin
					if (sweep_q == tcb_pkg::CHAN_W'(NCHAN - 1)) begin
						state_q <= tcb_pkg::ST_IDLE;
					end else begin
						state_q <= tcb_pkg::ST_SWEEP_RD;
					end
					sweep_q <= sweep_q + tcb_pkg::CHAN_W'(1);
				end
				default: begin
					state_q <= tcb_pkg::ST_IDLE;
				end
			endcase
		end
	end

	// a request is taken only while idle and running, so no word is read while written;
	// the channel compare is one bit wider so a full bank of 64 does not wrap to zero
	assign ev_ready = state_q == tcb_pkg::ST_IDLE && run_q && ctrl_q[tcb_pkg::CTRL_RUN_BIT]
		&& {1'b0, ev_chan} < (tcb_pkg::CHAN_W + 1)'(NCHAN);

	// memory steering; stopping clears timer words only, counters keep theirs
	always_comb begin
		mem_rd = 1'b0;
		mem_rd_addr = ev_chan;
		mem_wr = 1'b0;
		mem_wr_addr = chan_q;
		wr_word = calc_word;
		if (state_q == tcb_pkg::ST_IDLE) begin
			mem_rd = ev_req && ev_ready;
		end else if (state_q == tcb_pkg::ST_CALC) begin
			mem_wr = 1'b1;
		end else if (state_q == tcb_pkg::ST_SWEEP_RD) begin
			mem_rd = 1'b1;
			mem_rd_addr = sweep_q;
		end else if (state_q == tcb_pkg::ST_SWEEP_WR) begin
			mem_wr = rd_word[tcb_pkg::F_TIMER];
			mem_wr_addr = sweep_q;
			wr_word = {1'b0, 1'b1, 1'b0, 16'h0000};
		end
	end

	tcb_mem #(
		.WIDTH(tcb_pkg::WORD_W),
		.DEPTH(tcb_pkg::NUM_CHAN),
		.AW(tcb_pkg::CHAN_W)
	) u_mem (
		.ref_clk(ref_clk),
		.ce(ce),
		.rd_en(mem_rd),
		.rd_addr(mem_rd_addr),
		.rd_data(rd_word),
		.wr_en(mem_wr),
		.wr_addr(mem_wr_addr),
		.wr_data(wr_word)
	);

	// answer to the scan engine, registered
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			ev_ack <= 1'b0;
			ev_done <= 1'b0;
			ev_acc <= 16'h0000;
		end else if (ce) begin
			ev_ack <= state_q == tcb_pkg::ST_CALC;
			if (state_q == tcb_pkg::ST_CALC) begin
				ev_done <= calc_word[tcb_pkg::F_DONE];
				ev_acc <= calc_word[15:0];
			end
		end
	end
endmodule : tcb_bank
`default_nettype wire

// [rtl/tcb_mem.sv]
// channel state store with registered read data; no reset so values survive
`timescale 1ns/1ps
`default_nettype none
module tcb_mem #(
	parameter int WIDTH = 19,
	parameter int DEPTH = 64,
	parameter int AW = 6
) (
	input wire logic ref_clk,
	input wire logic ce,
	input wire logic rd_en,
	input wire logic [AW-1:0] rd_addr,
	output logic [WIDTH-1:0] rd_data,
	input wire logic wr_en,
	input wire logic [AW-1:0] wr_addr,
	input wire logic [WIDTH-1:0] wr_data
);
	logic [WIDTH-1:0] mem [DEPTH];

	if (DEPTH > (1 << AW)) begin : g_chk
		$error("tcb_mem: depth exceeds address range");
	end

	// write port; contents are kept across reset on purpose
	always_ff @(posedge ref_clk) begin
		if (ce && wr_en) begin
			mem[wr_addr] <= wr_data;
		end
	end

	// registered read port
	always_ff @(posedge ref_clk) begin
		if (ce && rd_en) begin
			rd_data <= mem[rd_addr];
		end
	end
endmodule : tcb_mem
`default_nettype wire

// [rtl/tcb_pkg.sv]
// shared constants for the scan timer/counter bank
package tcb_pkg;
	// channel numbering
	localparam int NUM_CHAN = 64;
	localparam int CHAN_W = 6;
	localparam int REF_FIRST = 'o600; // first channel reference
	localparam int REF_LAST = 'o677; // last channel reference
	localparam int REF_FINE_SEL = 'o770; // special reference for 0.01 s ticks
	localparam logic [CHAN_W-1:0] EXT_CHAN_BASE = 6'h3c; // channel 674
	localparam int NUM_EXT = 4;
	// preset register references, low then high byte, for channels 674..677
	localparam int REF_EXT_LO0 = 'o564;
	localparam int REF_EXT_HI0 = 'o565;
	localparam int REF_EXT_LO1 = 'o566;
	localparam int REF_EXT_HI1 = 'o567;
	localparam int REF_EXT_LO2 = 'o570;
	localparam int REF_EXT_HI2 = 'o571;
	localparam int REF_EXT_LO3 = 'o572;
	localparam int REF_EXT_HI3 = 'o573;
	// register port map (byte registers)
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_STATUS = 8'h01;
	localparam logic [7:0] ADDR_TICKS = 8'h02;
	localparam logic [7:0] ADDR_EXT_BASE = 8'h08; // 8 bytes, lo/hi per channel
	localparam int CTRL_FINE_BIT = 0;
	localparam int CTRL_RUN_BIT = 1;
	localparam int CTRL_EXTP_BIT = 2;
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic [15:0] EXT_PRESET_RESET = 16'h9999;
	// bcd limits
	localparam logic [15:0] BCD_MIN = 16'h0001;
	localparam logic [15:0] BCD_MAX = 16'h9999;
	// channel word layout
	localparam int ACC_W = 16;
	localparam int WORD_W = 19;
	localparam int F_DONE = 16;
	localparam int F_TIMER = 17;
	localparam int F_PREV = 18;
	// timing
	localparam int CLK_PERIOD_PS = 5000;
	localparam longint FINE_TICK_PS = 64'd10_000_000_000; // 0.01 s
	localparam int FINE_TICK_CYC = int'(FINE_TICK_PS / CLK_PERIOD_PS);
	localparam logic [3:0] COARSE_DIV = 4'h9; // ten fine ticks make 0.1 s
	localparam logic [3:0] MAX_SCAN_TICKS = 4'h9;
	typedef enum logic [1:0] {ST_IDLE, ST_CALC, ST_SWEEP_RD, ST_SWEEP_WR} tcb_state_e;
endpackage : tcb_pkg

// [tb/tcb_bank_properties.sv]
// concurrent checks on the timer/counter bank ports
`timescale 1ns/1ps
`default_nettype none
module tcb_bank_properties #(
	parameter int NCHAN = 64
) (
	input wire logic ref_clk,
	input wire logic resetn,
	input wire logic reg_rd,
	input wire logic [7:0] reg_rdata,
	input wire logic ev_req,
	input wire logic ev_ready,
	input wire logic [tcb_pkg::CHAN_W-1:0] ev_chan,
	input wire logic ev_is_timer,
	input wire logic ev_enable,
	input wire logic ev_reset,
	input wire logic ev_region_on,
	input wire logic ev_ack,
	input wire logic ev_done,
	input wire logic [15:0] ev_acc
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!resetn);
	// a request is taken, then answered two edges later
	sequence take_s;
		ev_req && ev_ready;
	endsequence
	sequence answer_s;
		!ev_ack ##1 ev_ack;
	endsequence
	a_ack_latency: assert property (take_s |=> answer_s)
		else $error("answer not two cycles after request");
	a_busy_after: assert property (take_s |=> !ev_ready)
		else $error("ready during evaluation");
	a_ack_pulse: assert property (ev_ack |=> !ev_ack)
		else $error("ack longer than one cycle");
	a_out_hold: assert property (!ev_ack |-> $stable(ev_acc) && $stable(ev_done))
		else $error("result changed without ack");
	a_acc_bcd: assert property (ev_ack |-> ev_acc[3:0] <= 4'h9 && ev_acc[7:4] <= 4'h9
		&& ev_acc[11:8] <= 4'h9 && ev_acc[15:12] <= 4'h9) else $error("value not bcd");
	a_ctr_reset: assert property (take_s and (!ev_is_timer && ev_reset && ev_region_on)
		|-> ##2 (ev_acc == 16'h0000 && !ev_done)) else $error("counter not held at zero");
	a_timer_clear: assert property (take_s and (ev_is_timer && !(ev_enable && ev_region_on))
		|-> ##2 (ev_acc == 16'h0000 && !ev_done)) else $error("timer not cleared");
	a_chan_range: assert property (ev_chan >= NCHAN |-> !ev_ready)
		else $error("ready for absent channel");
	a_rdata_quiet: assert property (!reg_rd |=> reg_rdata == 8'h00)
		else $error("read data without read");
endmodule : tcb_bank_properties
bind tcb_bank tcb_bank_properties #(.NCHAN(NCHAN)) u_props (.ref_clk(ref_clk), .resetn(resetn),
	.reg_rd(reg_rd), .reg_rdata(reg_rdata), .ev_req(ev_req), .ev_ready(ev_ready),
	.ev_chan(ev_chan), .ev_is_timer(ev_is_timer), .ev_enable(ev_enable), .ev_reset(ev_reset),
	.ev_region_on(ev_region_on), .ev_ack(ev_ack), .ev_done(ev_done), .ev_acc(ev_acc));
`default_nettype wire

// [tb/tcb_scan_model.sv]
// scan engine model: periodic scan starts, one request per command
`timescale 1ns/1ps
`default_nettype none
module tcb_scan_model #(
	parameter int SCAN = 80
) (
	input wire logic ref_clk,
	input wire logic resetn,
	input wire logic cmd_go,
	output logic cmd_done = 1'b0,
	output logic scan_start = 1'b0,
	output logic ev_req = 1'b0,
	input wire logic ev_ready,
	input wire logic ev_ack
);
	int cnt = 0;
	logic [1:0] st_q = 2'h0;
	// fixed scan length so every scan sees the same tick count
	always @(posedge ref_clk) begin
		cnt <= (cnt == SCAN - 1) ? 0 : cnt + 1;
		scan_start <= (cnt == SCAN - 1);
	end
	// request waits for a scan start and is held until taken
	always @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			st_q <= 2'h0;
			ev_req <= 1'b0;
			cmd_done <= 1'b0;
		end else begin
			cmd_done <= 1'b0;
			case (st_q)
			2'h0: if (cmd_go) st_q <= 2'h1;
			2'h1: if (scan_start) begin
				ev_req <= 1'b1;
				st_q <= 2'h2;
			end
			2'h2: if (ev_ready) begin
				ev_req <= 1'b0;
				st_q <= 2'h3;
			end
			default: if (ev_ack) begin
				cmd_done <= 1'b1;
				st_q <= 2'h0;
			end
			endcase
		end
	end
endmodule : tcb_scan_model
`default_nettype wire

// [tb/testbench.sv]
// self-checking bench for the scan timer/counter bank
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic ref_clk = 1'b0;
	logic resetn = 1'b0;
	logic ce = 1'b1;
	logic [7:0] reg_addr = 8'h00;
	logic [7:0] reg_wdata = 8'h00;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [7:0] reg_rdata;
	logic scan_start, ev_req, ev_ready, ev_ack, ev_done, done;
	logic [tcb_pkg::CHAN_W-1:0] ev_chan = 6'h00;
	logic ev_is_timer = 1'b0;
	logic ev_enable = 1'b0;
	logic ev_reset = 1'b0;
	logic ev_region_on = 1'b1;
	logic [15:0] ev_preset = 16'h0000;
	logic [15:0] ev_acc;
	logic ext_set = 1'b0;
	logic [1:0] ext_sel = 2'h0;
	logic [15:0] ext_bcd = 16'h0000;
	logic go = 1'b0;
	int mismatches = 0;
	int n_tests = 0;
	// 200 MHz clock
	always #2.5 ref_clk = ~ref_clk;
	// short fine tick keeps timer runs brief; two channels left absent on purpose
	tcb_bank #(.NCHAN(62), .FINE_TICK_CYC(4)) DUT (.ref_clk(ref_clk), .resetn(resetn), .ce(ce),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .scan_start(scan_start), .ev_req(ev_req), .ev_ready(ev_ready),
		.ev_chan(ev_chan), .ev_is_timer(ev_is_timer), .ev_enable(ev_enable),
		.ev_reset(ev_reset), .ev_region_on(ev_region_on), .ev_preset(ev_preset),
		.ev_ack(ev_ack), .ev_done(ev_done), .ev_acc(ev_acc), .ext_set(ext_set),
		.ext_sel(ext_sel), .ext_bcd(ext_bcd));
	tcb_scan_model #(.SCAN(80)) u_scan (.ref_clk(ref_clk), .resetn(resetn), .cmd_go(go),
		.cmd_done(done), .scan_start(scan_start), .ev_req(ev_req), .ev_ready(ev_ready),
		.ev_ack(ev_ack));
	task automatic finish_test();
		$display("comparisons %0d mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : finish_test
	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		n_tests++;
		if (got !== exp) begin
			mismatches++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : check
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask : wr
	// read data stand only in the cycle after the strobe
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		#1 check({8'h00, reg_rdata}, {8'h00, exp});
	endtask : rd
	task automatic pick(input logic [5:0] ch, input logic [15:0] pre);
		@(posedge ref_clk);
		ev_chan <= ch;
		ev_preset <= pre;
	endtask : pick
	// one evaluation in the next scan, then compare value and coil
	task automatic ev(input logic t, input logic en, input logic rs, input logic on,
		input logic [15:0] eacc, input logic edone);
		int i;
		@(posedge ref_clk);
		ev_is_timer <= t;
		ev_enable <= en;
		ev_reset <= rs;
		ev_region_on <= on;
		go <= 1'b1;
		@(posedge ref_clk);
		go <= 1'b0;
		for (i = 0; i < 300 && done !== 1'b1; i++) begin
			@(posedge ref_clk);
			#1;
		end
		if (i == 300) begin
			mismatches++;
			finish_test();
		end
		check(ev_acc, eacc);
		check({15'h0000, ev_done}, {15'h0000, edone});
	endtask : ev
	initial begin
		repeat (20) @(posedge ref_clk);
		resetn <= 1'b1;
		rd(8'h08, 8'h99);
		rd(8'h05, 8'h00);
		wr(8'h0c, 8'h55);
		rd(8'h0c, 8'h55);
		wr(8'h00, 8'h02);
		$display("register test done");
		pick(6'd3, 16'h0002);
		ev(0, 0, 1, 1, 16'h0000, 0);
		ev(0, 1, 0, 1, 16'h0001, 0);
		ev(0, 1, 0, 1, 16'h0001, 0);
		ev(0, 0, 0, 1, 16'h0001, 0);
		ev(0, 1, 0, 1, 16'h0002, 1);
		ev(0, 0, 0, 0, 16'h0002, 1);
		ev(0, 1, 0, 0, 16'h0002, 1);
		ev(0, 1, 1, 1, 16'h0000, 0);
		ev(0, 0, 0, 1, 16'h0000, 0);
		ev(0, 1, 0, 1, 16'h0001, 0);
		$display("counter test done");
		pick(6'd0, 16'h0003);
		ev(1, 0, 0, 1, 16'h0000, 0);
		ev(1, 1, 0, 1, 16'h0000, 0);
		ev(1, 1, 0, 1, 16'h0002, 0);
		ev(1, 1, 0, 1, 16'h0004, 1);
		ev(1, 0, 0, 1, 16'h0000, 0);
		ev(1, 1, 0, 1, 16'h0000, 0);
		ev(1, 1, 0, 0, 16'h0000, 0);
		wr(8'h00, 8'h03);
		pick(6'd1, 16'h0010);
		ev(1, 0, 0, 1, 16'h0000, 0);
		ev(1, 1, 0, 1, 16'h0000, 0);
		ev(1, 1, 0, 1, 16'h0009, 0);
		ev(1, 1, 0, 1, 16'h0018, 1);
		rd(8'h02, 8'h09);
		rd(8'h01, 8'h07);
		// stopping the processor sweeps the bank and clears every timer
		wr(8'h00, 8'h01);
		repeat (130) @(posedge ref_clk);
		wr(8'h00, 8'h03);
		pick(6'd1, 16'h0010);
		ev(1, 1, 0, 1, 16'h0000, 0);
		$display("timer test done");
		// counters keep their value through a reset
		resetn <= 1'b0;
		repeat (2) @(posedge ref_clk);
		resetn <= 1'b1;
		wr(8'h00, 8'h06);
		pick(6'd3, 16'h0002);
		ev(0, 1, 0, 1, 16'h0001, 0);
		@(posedge ref_clk);
		ext_sel <= 2'h1;
		ext_bcd <= 16'h0002;
		ext_set <= 1'b1;
		@(posedge ref_clk);
		ext_set <= 1'b0;
		rd(8'h0a, 8'h02);
		rd(8'h0b, 8'h00);
		pick(6'd61, 16'h0001);
		ev(0, 0, 1, 1, 16'h0000, 0);
		ev(0, 1, 0, 1, 16'h0001, 0);
		ev(0, 0, 0, 1, 16'h0001, 0);
		ev(0, 1, 0, 1, 16'h0002, 1);
		pick(6'd62, 16'h0001);
		#1 check({15'h0000, ev_ready}, 16'h0000);
		$display("external preset test done");
		finish_test();
	end
endmodule : testbench
`default_nettype wire
